// *** data_memory_regs.svh ***
// Address map, field positions and reset values of the banked data memory.
// Assumes a 12-bit banked address and a 16-bit linear address from the core.
`ifndef DATA_MEMORY_REGS_SVH
`define DATA_MEMORY_REGS_SVH

`define STATUS_OFF      7'h03
`define SFR_LO          7'h0C
`define SFR_HI          7'h1F
`define GPR_LO          7'h20
`define GPR_HI          7'h6F
`define SPLIT_HI        7'h2F
`define COMMON_LO       7'h70
`define FULL_LAST_BANK  5'h05
`define SPLIT_BANK      5'h06
`define BANK_BYTES      9'h050
`define SPLIT_BASE      9'h1E0
`define TAIL_BASE       9'h1F0
`define LIN_BASE        16'h2000
`define LIN_LAST        16'h21EF

`define ST_C_BIT        0
`define ST_DC_BIT       1
`define ST_Z_BIT        2
`define ST_PD_BIT       3
`define ST_TO_BIT       4
`define ARITH_RST       3'h0
`define CAUSE_RST       2'h3

`endif

// *** data_memory_pkg.sv ***
// Types shared by the data memory, its flag logic and its callers.
// Assumes the core tells which operation class produced a result.
package data_memory_pkg;

  typedef enum logic [2:0] {
    op_none  = 3'h0,
    op_logic = 3'h1,
    op_add   = 3'h3,
    op_sub   = 3'h2,
    op_rotr  = 3'h6,
    op_rotl  = 3'h7
  } alu_op_t;

endpackage

// *** alu_flags.sv ***
// Flag computation for one ALU operation, purely combinational.
// Assumes operands are stable in the cycle the operation is reported.
`timescale 1ns/10ps
module alu_flags (
  input  data_memory_pkg::alu_op_t op,
  input  logic [7:0]               a,
  input  logic [7:0]               b,
  input  logic                     carry_in,
  output logic                     z_en,
  output logic                     z_val,
  output logic                     dc_en,
  output logic                     dc_val,
  output logic                     c_en,
  output logic                     c_val
);
  import data_memory_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] addend;

  // Subtraction reuses the adder with the inverted operand and a forced carry in.
  always_comb begin
    addend = (op == op_sub) ? ~b : b;
    sum    = {1'b0, a} + {1'b0, addend} + {8'h00, op == op_sub};
    low    = {1'b0, a[3:0]} + {1'b0, addend[3:0]} + {4'h0, op == op_sub};
  end

  // Rotates touch only the carry; logic operations only the zero flag.
  always_comb begin
    z_en   = (op == op_logic) || (op == op_add) || (op == op_sub);
    z_val  = (op == op_logic) ? (a == 8'h00) : (sum[7:0] == 8'h00);
    dc_en  = (op == op_add) || (op == op_sub);
    dc_val = low[4];
    c_en   = dc_en || (op == op_rotr) || (op == op_rotl);
    c_val  = sum[8];
    if (op == op_rotr) begin
      c_val = a[0];
    end else if (op == op_rotl) begin
      c_val = a[7];
    end
    if (carry_in && 1'b0) begin
      c_val = 1'b0;
    end
  end

endmodule

// *** dual_port_ram.sv ***
// Shared buffer memory with one port for the core and one for the USB engine.
// Reads are combinational; the caller registers them.
`timescale 1ns/10ps
module dual_port_ram (
  input  logic       clock,
  input  logic       a_we,
  input  logic [8:0] a_idx,
  input  logic [7:0] a_wdata,
  output logic [7:0] a_rdata,
  input  logic       b_we,
  input  logic [8:0] b_idx,
  input  logic [7:0] b_wdata,
  output logic [7:0] b_rdata
);
  logic [7:0] mem [0:511];

  // Both ports see the contents from before this cycle's writes.
  assign a_rdata = mem[a_idx];
  assign b_rdata = mem[b_idx];

  // A same-location collision keeps the core's byte so no mix of the two lands.
  always_ff @(posedge clock) begin
    if (a_we) begin
      mem[a_idx] <= a_wdata;
    end
    if (b_we && !(a_we && (a_idx == b_idx))) begin
      mem[b_idx] <= b_wdata;
    end
  end

endmodule

// *** data_memory_core.sv ***
// Banked data memory front end: status register, common RAM, shared USB buffer
// and peripheral pass-through. Assumes one core access per cycle and that the
// peripherals decode cpu_addr themselves and drive sfr_rdata combinationally.
`timescale 1ns/10ps
`include "data_memory_regs.svh"
module data_memory_core (
  input  logic                     clock,
  input  logic                     srst,
  input  logic                     power_on_reset,
  input  logic                     cpu_rd,
  input  logic                     cpu_wr,
  input  logic                     cpu_linear,
  input  logic [15:0]              cpu_addr,
  input  logic [7:0]               cpu_wdata,
  output logic [7:0]               cpu_rdata,
  input  logic                     alu_update,
  input  data_memory_pkg::alu_op_t alu_op,
  input  logic [7:0]               alu_a,
  input  logic [7:0]               alu_b,
  input  logic                     watchdog_kick_instr,
  input  logic                     sleep_instr,
  input  logic                     watchdog_timeout,
  input  logic [7:0]               sfr_rdata,
  output logic                     sfr_wr,
  output logic [6:0]               sfr_offset,
  output logic [7:0]               sfr_wdata,
  input  logic                     usb_enable,
  input  logic                     usb_rd,
  input  logic                     usb_wr,
  input  logic                     usb_linear,
  input  logic [15:0]              usb_addr,
  input  logic [7:0]               usb_wdata,
  output logic [7:0]               usb_rdata
);
  import data_memory_pkg::*;

  // Maps a banked or linear address into the 512-byte shared buffer.
  // Bit 9 of the answer says whether the address lands there at all.
  function automatic logic [9:0] map_dpr(input logic lin, input logic [15:0] addr);
    logic [4:0] bank;
    logic [6:0] off;
    logic [9:0] res;
    bank = addr[11:7];
    off  = addr[6:0];
    res  = 10'h000;
    if (lin) begin
      if (addr >= `LIN_BASE && addr <= `LIN_LAST) begin
        res = {1'b1, 9'(addr - `LIN_BASE)};
      end
    end else if (off >= `GPR_LO && off <= `GPR_HI && bank <= `FULL_LAST_BANK) begin
      res = {1'b1, 9'(9'(bank) * `BANK_BYTES) + 9'(off - `GPR_LO)};
    end else if (bank == `SPLIT_BANK && off >= `GPR_LO && off <= `SPLIT_HI) begin
      res = {1'b1, `SPLIT_BASE + 9'(off - `GPR_LO)};
    end else if (bank == `SPLIT_BANK && off >= `COMMON_LO) begin
      res = {1'b1, `TAIL_BASE + 9'(off - `COMMON_LO)};
    end
    return res;
  endfunction

  // Status fields.
  logic       watchdog_expiry_flag;
  logic       sleep_entered_flag;
  logic       result_null_flag;
  logic       nibble_overflow_flag;
  logic       msb_overflow_flag;
  logic [7:0] status_byte;

  // Decode of the core and USB addresses.
  logic [9:0] cpu_map;
  logic [9:0] usb_map;
  logic       cpu_dpr_hit;
  logic [8:0] cpu_dpr_idx;
  logic       usb_dpr_hit;
  logic [8:0] usb_dpr_idx;
  logic [6:0] cpu_off;
  logic       cpu_is_status;
  logic       cpu_is_sfr;
  logic       cpu_is_common;
  logic       status_wr;

  // Flag logic results.
  logic       z_en;
  logic       z_val;
  logic       dc_en;
  logic       dc_val;
  logic       c_en;
  logic       c_val;

  // Shared buffer and common RAM.
  logic [7:0] dpr_a_rdata;
  logic [7:0] dpr_b_rdata;
  logic       dpr_a_we;
  logic       dpr_b_we;
  logic [7:0] common_mem [0:15];
  logic [7:0] next_cpu_rdata;
  logic [7:0] next_usb_rdata;

  // The same mapping serves both ports, so a buffer address means one byte.
  always_comb begin
    cpu_map     = map_dpr(cpu_linear, cpu_addr);
    usb_map     = map_dpr(usb_linear, usb_addr);
    cpu_dpr_hit = cpu_map[9];
    cpu_dpr_idx = cpu_map[8:0];
    usb_dpr_hit = usb_map[9];
    usb_dpr_idx = usb_map[8:0];
  end

  // Region decode of the bank offset for the core port.
  always_comb begin
    cpu_off       = cpu_addr[6:0];
    cpu_is_status = !cpu_linear && (cpu_off == `STATUS_OFF);
    cpu_is_sfr    = !cpu_linear && (cpu_off >= `SFR_LO) && (cpu_off <= `SFR_HI);
    cpu_is_common = !cpu_linear && (cpu_off >= `COMMON_LO) && !cpu_dpr_hit;
    status_wr     = cpu_wr && cpu_is_status && !srst;
  end

  // The status byte as the core reads it; the top three bits are not built.
  always_comb begin
    status_byte               = 8'h00;
    status_byte[`ST_TO_BIT]   = watchdog_expiry_flag;
    status_byte[`ST_PD_BIT]   = sleep_entered_flag;
    status_byte[`ST_Z_BIT]    = result_null_flag;
    status_byte[`ST_DC_BIT]   = nibble_overflow_flag;
    status_byte[`ST_C_BIT]    = msb_overflow_flag;
  end

  alu_flags u_flags (
    .op       (alu_op),
    .a        (alu_a),
    .b        (alu_b),
    .carry_in (msb_overflow_flag),
    .z_en     (z_en),
    .z_val    (z_val),
    .dc_en    (dc_en),
    .dc_val   (dc_val),
    .c_en     (c_en),
    .c_val    (c_val)
  );

  // Arithmetic flags. Only power-on clears them; the ordinary reset freezes
  // them so software can inspect the state left before the reset.
  always_ff @(posedge clock) begin
    if (power_on_reset) begin
      {result_null_flag, nibble_overflow_flag, msb_overflow_flag} <= `ARITH_RST;
    end else if (srst) begin
      result_null_flag <= result_null_flag;
    end else if (alu_update) begin
      // The computed value wins over a write aimed at the same bits.
      if (z_en) begin
        result_null_flag <= z_val;
      end
      if (dc_en) begin
        nibble_overflow_flag <= dc_val;
      end
      if (c_en) begin
        msb_overflow_flag <= c_val;
      end
      if (status_wr && !z_en) begin
        result_null_flag <= cpu_wdata[`ST_Z_BIT];
      end
      if (status_wr && !dc_en) begin
        nibble_overflow_flag <= cpu_wdata[`ST_DC_BIT];
      end
      if (status_wr && !c_en) begin
        msb_overflow_flag <= cpu_wdata[`ST_C_BIT];
      end
    end else if (status_wr) begin
      result_null_flag     <= cpu_wdata[`ST_Z_BIT];
      nibble_overflow_flag <= cpu_wdata[`ST_DC_BIT];
      msb_overflow_flag    <= cpu_wdata[`ST_C_BIT];
    end
  end

  // Reset-cause flags ignore core writes. Events still land during the
  // ordinary reset, which is what makes their value depend on its cause.
  always_ff @(posedge clock) begin
    if (power_on_reset) begin
      {watchdog_expiry_flag, sleep_entered_flag} <= `CAUSE_RST;
    end else begin
      if (watchdog_kick_instr || sleep_instr) begin
        watchdog_expiry_flag <= 1'b1;
      end else if (watchdog_timeout) begin
        watchdog_expiry_flag <= 1'b0;
      end
      if (watchdog_kick_instr) begin
        sleep_entered_flag <= 1'b1;
      end else if (sleep_instr) begin
        sleep_entered_flag <= 1'b0;
      end
    end
  end

  // The USB side only reaches the buffer while the engine is switched on.
  always_comb begin
    dpr_a_we = cpu_wr && cpu_dpr_hit && !srst;
    dpr_b_we = usb_wr && usb_dpr_hit && usb_enable && !srst;
  end

  dual_port_ram u_dpr (
    .clock   (clock),
    .a_we    (dpr_a_we),
    .a_idx   (cpu_dpr_idx),
    .a_wdata (cpu_wdata),
    .a_rdata (dpr_a_rdata),
    .b_we    (dpr_b_we),
    .b_idx   (usb_dpr_idx),
    .b_wdata (usb_wdata),
    .b_rdata (dpr_b_rdata)
  );

  // Common RAM is indexed by the low offset bits alone, so it is bank blind.
  always_ff @(posedge clock) begin
    if (cpu_wr && cpu_is_common && !srst) begin
      common_mem[cpu_off[3:0]] <= cpu_wdata;
    end
  end

  // Read selection for the core; anything not decoded answers zero.
  always_comb begin
    next_cpu_rdata = 8'h00;
    if (cpu_is_status) begin
      next_cpu_rdata = status_byte;
    end else if (cpu_is_sfr) begin
      next_cpu_rdata = sfr_rdata;
    end else if (cpu_dpr_hit) begin
      next_cpu_rdata = dpr_a_rdata;
    end else if (cpu_is_common) begin
      next_cpu_rdata = common_mem[cpu_off[3:0]];
    end
  end

  // A disabled engine reads zero rather than stale buffer contents.
  always_comb begin
    next_usb_rdata = 8'h00;
    if (usb_enable && usb_dpr_hit) begin
      next_usb_rdata = dpr_b_rdata;
    end
  end

  // Read data is registered and holds until the next read or a reset, which clears it.
  always_ff @(posedge clock) begin
    if (srst || power_on_reset) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= next_cpu_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || power_on_reset) begin
      usb_rdata <= 8'h00;
    end else if (usb_rd) begin
      usb_rdata <= next_usb_rdata;
    end
  end

  // Peripheral writes are forwarded one cycle late, as a single-cycle strobe.
  always_ff @(posedge clock) begin
    if (srst || power_on_reset) begin
      sfr_wr     <= 1'b0;
      sfr_offset <= 7'h00;
      sfr_wdata  <= 8'h00;
    end else begin
      sfr_wr <= cpu_wr && cpu_is_sfr;
      if (cpu_wr && cpu_is_sfr) begin
        sfr_offset <= cpu_off;
        sfr_wdata  <= cpu_wdata;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst || power_on_reset);

  sequence s_cpu_buf_write;
    cpu_wr && cpu_dpr_hit && usb_enable;
  endsequence

  sequence s_usb_same_read;
    usb_rd && usb_enable && usb_dpr_hit && (usb_dpr_idx == $past(cpu_dpr_idx))
      && !(cpu_wr && cpu_dpr_hit && (cpu_dpr_idx == usb_dpr_idx));
  endsequence

  sequence s_status_read;
    cpu_rd && cpu_is_status;
  endsequence

  a_upper_bits_zero:
    assert property (s_status_read |=> cpu_rdata[7:5] == 3'h0)
      else $error("status upper bits not zero");

  a_timeout_clears:
    assert property (watchdog_timeout && !watchdog_kick_instr && !sleep_instr
                     |=> !watchdog_expiry_flag)
      else $error("watchdog expiry flag not cleared by timeout");

  a_kick_sets_both:
    assert property (watchdog_kick_instr |=> watchdog_expiry_flag && sleep_entered_flag)
      else $error("watchdog kick did not set both cause flags");

  a_sleep_marks:
    assert property (sleep_instr && !watchdog_kick_instr
                     |=> !sleep_entered_flag && watchdog_expiry_flag)
      else $error("sleep did not mark power down");

  a_por_values:
    assert property (@(posedge clock) disable iff (srst)
                     power_on_reset |=> status_byte == 8'h18)
      else $error("power-on status value wrong");

  a_reset_keeps:
    assert property (@(posedge clock) disable iff (power_on_reset)
                     srst |=> $stable(status_byte[2:0]))
      else $error("arithmetic flags changed during reset");

  a_add_carry:
    assert property (alu_update && alu_op == op_add
                     |=> msb_overflow_flag == $past(9'(alu_a) + 9'(alu_b) > 9'h0FF))
      else $error("add carry wrong");

  a_sub_borrow:
    assert property (alu_update && alu_op == op_sub
                     |=> msb_overflow_flag == $past(alu_a >= alu_b)
                         && result_null_flag == $past(alu_a == alu_b))
      else $error("subtract borrow polarity wrong");

  a_rotate_right:
    assert property (alu_update && alu_op == op_rotr |=> msb_overflow_flag == $past(alu_a[0]))
      else $error("rotate right carry wrong");

  a_write_dropped:
    assert property (alu_update && alu_op == op_logic && status_wr
                     |=> result_null_flag == $past(alu_a == 8'h00))
      else $error("status write overrode computed zero flag");

  a_usb_off_zero:
    assert property (usb_rd && !usb_enable |=> usb_rdata == 8'h00)
      else $error("disabled usb port returned data");

  a_buffer_handoff:
    assert property (s_cpu_buf_write ##1 s_usb_same_read |=> usb_rdata == $past(cpu_wdata, 2))
      else $error("usb did not see core byte");

  a_unmapped_zero:
    assert property (cpu_rd && !cpu_is_status && !cpu_is_sfr && !cpu_dpr_hit && !cpu_is_common
                     |=> cpu_rdata == 8'h00)
      else $error("unmapped read not zero");

endmodule

// *** periph_model.sv ***
// Behavioural peripheral register file standing behind the data memory.
// Assumes the core forwards writes to offsets 0C-1F and reads sfr_rdata at once.
`timescale 1ns/10ps
module periph_model (
  input  wire logic        clock,
  input  wire logic        cpu_linear,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        sfr_wr,
  input  wire logic [6:0]  sfr_offset,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata
);
  logic [7:0] regs [32];

  // One byte per offset; the bank is ignored, which is enough to see forwarding.
  always_ff @(posedge clock) begin
    if (sfr_wr) begin
      regs[sfr_offset[4:0]] <= sfr_wdata;
    end
  end

  // Outside the peripheral area the model drives a changing pattern, never a held value.
  always_comb begin
    if (!cpu_linear && cpu_addr[6:0] >= 7'h0C && cpu_addr[6:0] <= 7'h1F) begin
      sfr_rdata = regs[cpu_addr[4:0]];
    end else begin
      sfr_rdata = ~cpu_addr[7:0];
    end
  end
endmodule

// *** banked_data_memory_and_status_test.sv ***
// Self-checking bench for the banked data memory and its status register.
// Assumes the design package and header are compiled before this file.
`timescale 1ns/10ps
module banked_data_memory_and_status_test;
  import data_memory_pkg::*;
  logic clock, srst, power_on_reset, cpu_rd, cpu_wr, cpu_linear, alu_update;
  logic watchdog_kick_instr, sleep_instr, watchdog_timeout, sfr_wr;
  logic usb_enable, usb_rd, usb_wr, usb_linear;
  logic [15:0] cpu_addr, usb_addr;
  logic [7:0] cpu_wdata, cpu_rdata, alu_a, alu_b, sfr_rdata, sfr_wdata, usb_wdata, usb_rdata;
  logic [6:0] sfr_offset;
  alu_op_t alu_op;
  int error_cnt = 0;
  int num_checks = 0;
  integer seed = 32'h26b1_ceba;
  logic st_to, st_pd;
  logic [2:0] fl;
  logic [7:0] d;
  logic [15:0] ba, la;
  int idx;
  alu_op_t ops[5] = '{op_logic, op_add, op_sub, op_rotr, op_rotl};
  logic [2:0] ev[4] = '{3'b001, 3'b010, 3'b001, 3'b100};

  data_memory_core DUT (.clock(clock), .srst(srst), .power_on_reset(power_on_reset),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_linear(cpu_linear), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .alu_update(alu_update), .alu_op(alu_op),
    .alu_a(alu_a), .alu_b(alu_b), .watchdog_kick_instr(watchdog_kick_instr),
    .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout), .sfr_rdata(sfr_rdata),
    .sfr_wr(sfr_wr), .sfr_offset(sfr_offset), .sfr_wdata(sfr_wdata),
    .usb_enable(usb_enable), .usb_rd(usb_rd), .usb_wr(usb_wr), .usb_linear(usb_linear),
    .usb_addr(usb_addr), .usb_wdata(usb_wdata), .usb_rdata(usb_rdata));

  periph_model peri (.clock(clock), .cpu_linear(cpu_linear), .cpu_addr(cpu_addr),
    .sfr_wr(sfr_wr), .sfr_offset(sfr_offset), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // A hang is cut short here and reported as a failure.
  initial begin
    #200_000;
    error_cnt++;
    end_sim();
  end

  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Lets one rising edge take the request, then drops every pulse at the falling edge.
  task automatic tick();
    @(posedge clock);
    @(negedge clock);
    {cpu_rd, cpu_wr, usb_rd, usb_wr, alu_update} = 5'h00;
    {watchdog_kick_instr, sleep_instr, watchdog_timeout} = 3'h0;
  endtask

  task automatic wr(logic lin, logic [15:0] a, logic [7:0] v);
    {cpu_wr, cpu_linear, cpu_addr, cpu_wdata} = {1'b1, lin, a, v};
    tick();
  endtask

  task automatic rd(logic lin, logic [15:0] a, logic [7:0] exp);
    {cpu_rd, cpu_linear, cpu_addr} = {1'b1, lin, a};
    tick();
    chk("cpu_rdata", exp, cpu_rdata);
  endtask

  task automatic uwr(logic lin, logic [15:0] a, logic [7:0] v);
    {usb_wr, usb_linear, usb_addr, usb_wdata} = {1'b1, lin, a, v};
    tick();
  endtask

  task automatic urd(logic lin, logic [15:0] a, logic [7:0] exp);
    {usb_rd, usb_linear, usb_addr} = {1'b1, lin, a};
    tick();
    chk("usb_rdata", exp, usb_rdata);
  endtask

  // Status sits at offset 03 of every bank, so a random bank is used each time.
  task automatic status();
    rd(1'b0, {4'h0, 5'($random(seed)), 7'h03}, {3'b000, st_to, st_pd, fl});
  endtask

  function automatic logic [2:0] flg(alu_op_t op, logic [7:0] a, logic [7:0] b, logic [2:0] old);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] bb;
    bb = (op == op_sub) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + 9'(op == op_sub);
    n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(op == op_sub);
    case (op)
      op_add, op_sub: flg = {s[7:0] == 8'h00, n[4], s[8]};
      op_logic: flg = {a == 8'h00, old[1:0]};
      op_rotr: flg = {old[2:1], a[0]};
      op_rotl: flg = {old[2:1], a[7]};
      default: flg = old;
    endcase
  endfunction

  task automatic alu(alu_op_t op, logic [7:0] a, logic [7:0] b);
    {alu_update, alu_op, alu_a, alu_b} = {1'b1, op, a, b};
    fl = flg(op, a, b, fl);
    tick();
  endtask

  initial begin
    {srst, power_on_reset, cpu_rd, cpu_wr, cpu_linear, usb_rd, usb_wr, usb_linear} = 8'hC0;
    {cpu_addr, usb_addr, cpu_wdata, usb_wdata, alu_a, alu_b} = '0;
    {alu_update, watchdog_kick_instr, sleep_instr, watchdog_timeout, usb_enable} = 5'h01;
    alu_op = op_none;
    repeat (12) @(posedge clock);
    @(negedge clock);
    {srst, power_on_reset} = 2'b00;
    {st_to, st_pd, fl} = 5'h18;
    status();
    // Cause events, each followed by a random status write that must not touch them.
    for (int i = 0; i < 4; i++) begin
      {watchdog_kick_instr, sleep_instr, watchdog_timeout} = ev[i];
      if (ev[i][2]) {st_to, st_pd} = 2'b11;
      if (ev[i][1]) {st_to, st_pd} = 2'b10;
      if (ev[i][0]) st_to = 1'b0;
      tick();
      status();
      d = 8'($random(seed)) | 8'hE0;
      wr(1'b0, 16'h0003, d);
      fl = d[2:0];
      status();
    end
    // Corner cases first, then random operations.
    alu(op_add, 8'hFF, 8'h01);
    status();
    alu(op_sub, 8'h05, 8'h05);
    status();
    alu(op_sub, 8'h00, 8'h01);
    status();
    alu(op_rotl, 8'h80, 8'h00);
    status();
    for (int i = 0; i < 40; i++) begin
      alu(ops[$unsigned($random(seed)) % 5], 8'($random(seed)), 8'($random(seed)));
      status();
    end
    // A status write in the same cycle as an ALU update lands only on the flags the operation leaves alone.
    {cpu_wr, cpu_linear, cpu_addr, cpu_wdata} = {1'b1, 1'b0, 16'h0083, 8'h00};
    alu(op_add, 8'hFF, 8'h01);
    status();
    {cpu_wr, cpu_linear, cpu_addr, cpu_wdata} = {1'b1, 1'b0, 16'h0003, 8'h03};
    alu(op_logic, 8'h00, 8'h00);
    fl[1:0] = 2'b11;
    status();
    srst = 1'b1;
    tick();
    srst = 1'b0;
    chk("cpu_rdata", 8'h00, cpu_rdata);
    status();
    // Buffer bytes seen through banked and linear maps from both ports.
    for (int i = 0; i < 24; i++) begin
      idx = $unsigned($random(seed)) % 480;
      ba = 16'(idx / 80 * 128 + idx % 80 + 32);
      la = 16'(16'h2000 + idx);
      d = 8'($random(seed));
      if (i[0]) wr(1'b0, ba, d);
      else uwr(1'b1, la, d);
      rd(1'b1, la, d);
      urd(1'b0, ba, d);
    end
    wr(1'b0, 16'h032F, 8'h6D);
    rd(1'b1, 16'h21EF, 8'h6D);
    wr(1'b0, 16'h0370, 8'h92);
    urd(1'b0, 16'h0370, 8'h92);
    rd(1'b1, 16'h21F0, 8'h00);
    rd(1'b0, 16'h03A0, 8'h00);
    wr(1'b0, 16'h0075, 8'h4E);
    rd(1'b0, 16'h01F5, 8'h4E);
    rd(1'b0, 16'h0F75, 8'h4E);
    // With the USB function off the engine neither reads nor writes.
    usb_enable = 1'b0;
    wr(1'b0, 16'h00A0, 8'h11);
    uwr(1'b1, 16'h2050, 8'h5A);
    rd(1'b1, 16'h2050, 8'h11);
    urd(1'b1, 16'h2050, 8'h00);
    usb_enable = 1'b1;
    // Both ports write one byte in the same cycle; the core byte survives.
    {usb_wr, usb_linear, usb_addr, usb_wdata} = {1'b1, 1'b1, 16'h2050, 8'h3C};
    wr(1'b1, 16'h2050, 8'hA5);
    urd(1'b0, 16'h00A0, 8'hA5);
    // Peripheral area forwarding at both ends of the range.
    wr(1'b0, 16'h028C, 8'h77);
    chk("sfr_wr", 8'h01, {7'h00, sfr_wr});
    chk("sfr_offset", 8'h0C, {1'b0, sfr_offset});
    chk("sfr_wdata", 8'h77, sfr_wdata);
    wr(1'b0, 16'h009F, 8'h81);
    chk("sfr_offset", 8'h1F, {1'b0, sfr_offset});
    wr(1'b0, 16'h000B, 8'h22);
    chk("sfr_wr", 8'h00, {7'h00, sfr_wr});
    wr(1'b0, 16'h0020, 8'h23);
    chk("sfr_wr", 8'h00, {7'h00, sfr_wr});
    rd(1'b0, 16'h000C, 8'h77);
    end_sim();
  end
endmodule
